/* File: rtl/mic_pkg.sv */
package mic_pkg;
    // register offsets (word indices, byte address is the offset times four)
    localparam logic [7:0] MIC_IDX_IRQ_CONTROL = 8'h0b;
    localparam logic [7:0] MIC_IDX_PERIPH_FLAGS = 8'h0c;
    localparam logic [7:0] MIC_IDX_PERIPH_ENABLES = 8'h8c;
    localparam logic [7:0] MIC_IDX_OPTION = 8'h81;
    localparam logic [7:0] MIC_IDX_CPU_STATUS = 8'h90;
    localparam int MIC_ADDR_W = 10;
    localparam logic [9:0] MIC_ADDR_IRQ_CONTROL = {MIC_IDX_IRQ_CONTROL, 2'b00};
    localparam logic [9:0] MIC_ADDR_PERIPH_FLAGS = {MIC_IDX_PERIPH_FLAGS, 2'b00};
    localparam logic [9:0] MIC_ADDR_PERIPH_ENABLES = {MIC_IDX_PERIPH_ENABLES, 2'b00};
    localparam logic [9:0] MIC_ADDR_OPTION = {MIC_IDX_OPTION, 2'b00};
    localparam logic [9:0] MIC_ADDR_CPU_STATUS = {MIC_IDX_CPU_STATUS, 2'b00};
    // irq_control field positions
    localparam int MIC_GIE_BIT = 7;
    localparam int MIC_PERIPHERAL_IRQ_ENABLE_BIT = 6;
    localparam int MIC_TIMER0_OVERFLOW_ENABLE_BIT = 5;
    localparam int MIC_EXTIE_BIT = 4;
    localparam int MIC_PCIE_BIT = 3;
    localparam int MIC_TIMER0_OVERFLOW_FLAG_BIT = 2;
    localparam int MIC_EXTIF_BIT = 1;
    localparam int MIC_PCIF_BIT = 0;
    // option register field
    localparam int MIC_EDGE_SEL_BIT = 6;
    // reset values, peripheral flag mask, vector address
    localparam logic [7:0] MIC_IRQ_CONTROL_RST = 8'h00;
    localparam logic [7:0] MIC_PERIPH_RST = 8'h00;
    localparam logic [7:0] MIC_OPTION_RST = 8'hff;
    localparam logic [7:0] MIC_PERIPH_MASK = 8'hf7;
    localparam logic [12:0] MIC_VECTOR = 13'h0004;
    // timing: quadrature phases per instruction cycle, vector latency
    localparam int MIC_QPHASES = 4;
    localparam int MIC_SYNC_LATENCY_TCY = 3;
    localparam logic [1:0] MIC_Q1 = 2'd0;
    localparam logic [1:0] MIC_Q2 = 2'd1;
    localparam logic [1:0] MIC_Q4 = 2'd3;
    localparam logic [1:0] MIC_AXI_OKAY = 2'b00;
    localparam logic [1:0] MIC_AXI_DECERR = 2'b11;

    // peripheral event strobes
    typedef struct packed {
        logic eeprom_done;
        logic comparator;
        logic serial_rx;
        logic serial_tx;
        logic capture_compare;
        logic timer2_match;
        logic timer1_overflow;
    } mic_periph_ev_type;

    // core sequencer handshake
    typedef struct packed {
        logic instr_done;
        logic return_from_isr;
        logic sleep_enter;
    } mic_core_ev_type;

    typedef enum logic [2:0] {
        MIC_RUN = 3'b001,
        MIC_ENTRY = 3'b010,
        MIC_SLEEP = 3'b100
    } mic_state_type;
endpackage : mic_pkg

/* File: rtl/mic_irq_ctrl.sv */
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// RULE1: ten request sources collected
// RULE2: bit 7 global enable gates all
// RULE3: reset clears global enable
// RULE4: return from isr sets global enable
// RULE5: accept clears enable, push, vector 0004h
// RULE6: peripheral flags/enables in own registers
// RULE7: latency three to four instruction cycles
// RULE8: flags set regardless of enables
// RULE9: clearing global enable forces nop, pending
// RULE10: edge select picks rising or falling
// RULE11: valid edge sets ext flag bit 1
// RULE12: ext request wakes from sleep
// RULE13: timer0 rollover sets bit 2 flag
// RULE14: upper port change sets bit 0
// RULE15: change at q2 read may miss
// RULE16: ext flag sampled every q1; here a valid edge sets the flag in any q phase
// RULE17: only return pc saved
// RULE18: software clears flag before re-enable
// RULE19: enabled flag wakes regardless of global
// RULE20: request is global and gated sources
module mic_irq_ctrl
    import mic_pkg::*;
#(
    parameter int PC_W = 13
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [MIC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [MIC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_irq_pin,
    input wire logic [3:0] port_upper_pins,
    input wire logic port_read,
    input wire logic timer0_rollover,
    input wire mic_periph_ev_type periph_ev,
    input wire mic_core_ev_type core_ev,
    input wire logic [PC_W-1:0] next_pc,
    output logic [1:0] q_phase,
    output logic irq_request,
    output logic force_nop,
    output logic vector_load,
    output logic [PC_W-1:0] vector_pc,
    output logic stack_push,
    output logic [PC_W-1:0] stack_push_pc,
    output logic sleeping,
    output logic wake_up
);
    initial begin
        if (PC_W < 13 || PC_W > 16) begin
            $error("mic_irq_ctrl: PC_W must be 13..16");
        end
    end

    logic [7:0] irq_control_r;
    logic [7:0] periph_flags_r;
    logic [7:0] periph_enables_r;
    logic [7:0] option_r;
    logic [1:0] q_phase_r;
    logic ext_pin_d_r;
    logic [3:0] port_latch_r;
    logic [1:0] lat_cnt_r;
    logic gie_clr_nop_r;
    mic_state_type state_r;
    logic q1;
    logic q4;
    logic ext_edge;
    logic port_change;
    logic [7:0] periph_set;
    logic ctl_pending;
    logic per_pending;
    logic any_pending;
    logic accept;
    logic aw_hold_r;
    logic w_hold_r;
    logic [MIC_ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic wr_fire;
    logic wr_ctl;
    logic wr_pflag;
    logic wr_pen;
    logic wr_opt;
    logic [7:0] wbyte;

    // quadrature phase counter, one instruction cycle per four clocks
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_phase_r <= MIC_Q1;
        end else if (state_r != MIC_SLEEP) begin
            q_phase_r <= q_phase_r + 2'd1;
        end
    end
    assign q_phase = q_phase_r;
    assign q1 = (q_phase_r == MIC_Q1);
    assign q4 = (q_phase_r == MIC_Q4);

    // RULE10: edge selection
    // external pin edge detect, polarity from option bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_pin_d_r <= 1'b0;
        end else begin
            ext_pin_d_r <= ext_irq_pin;
        end
    end
    assign ext_edge = option_r[MIC_EDGE_SEL_BIT] ? (ext_irq_pin && !ext_pin_d_r)
                                                 : (!ext_irq_pin && ext_pin_d_r);

    // RULE14: port change compare
    // RULE15: read window miss
    // latch refreshed on a port read in q2 only; change at q2 read is absorbed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_latch_r <= 4'h0;
        end else if (port_read && q_phase_r == MIC_Q2) begin
            port_latch_r <= port_upper_pins;
        end
    end
    assign port_change = (port_upper_pins != port_latch_r) &&
                         !(port_read && q_phase_r == MIC_Q2);

    // RULE1: peripheral source mapping
    always_comb begin
        periph_set = 8'h00;
        periph_set[7] = periph_ev.eeprom_done;
        periph_set[6] = periph_ev.comparator;
        periph_set[5] = periph_ev.serial_rx;
        periph_set[4] = periph_ev.serial_tx;
        periph_set[2] = periph_ev.capture_compare;
        periph_set[1] = periph_ev.timer2_match;
        periph_set[0] = periph_ev.timer1_overflow;
    end

    // axi write channel capture, address and data in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_hold_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_hold_r <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
    assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
    assign wr_fire = aw_hold_r && w_hold_r;
    assign wbyte = wstrb_r[0] ? wdata_r[7:0] : 8'h00;
    assign wr_ctl = wr_fire && wstrb_r[0] && awaddr_r == MIC_ADDR_IRQ_CONTROL;
    assign wr_pflag = wr_fire && wstrb_r[0] && awaddr_r == MIC_ADDR_PERIPH_FLAGS;
    assign wr_pen = wr_fire && wstrb_r[0] && awaddr_r == MIC_ADDR_PERIPH_ENABLES;
    assign wr_opt = wr_fire && wstrb_r[0] && awaddr_r == MIC_ADDR_OPTION;

    // write response, decode error for unmapped addresses
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= MIC_AXI_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_r == MIC_ADDR_IRQ_CONTROL ||
                            awaddr_r == MIC_ADDR_PERIPH_FLAGS ||
                            awaddr_r == MIC_ADDR_PERIPH_ENABLES ||
                            awaddr_r == MIC_ADDR_OPTION ||
                            awaddr_r == MIC_ADDR_CPU_STATUS) ? MIC_AXI_OKAY : MIC_AXI_DECERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // RULE20: request gating
    assign ctl_pending = (irq_control_r[MIC_TIMER0_OVERFLOW_ENABLE_BIT] && irq_control_r[MIC_TIMER0_OVERFLOW_FLAG_BIT]) ||
                         (irq_control_r[MIC_EXTIE_BIT] && irq_control_r[MIC_EXTIF_BIT]) ||
                         (irq_control_r[MIC_PCIE_BIT] && irq_control_r[MIC_PCIF_BIT]);
    assign per_pending = irq_control_r[MIC_PERIPHERAL_IRQ_ENABLE_BIT] &&
                         |(periph_flags_r & periph_enables_r & MIC_PERIPH_MASK);
    assign any_pending = ctl_pending || per_pending;
    // RULE2: global gate
    assign irq_request = irq_control_r[MIC_GIE_BIT] && any_pending;

    // RULE3: reset clears enables
    // RULE8: flags set regardless of enables
    // RULE11: ext flag bit 1
    // RULE13: timer0 flag bit 2
    // RULE16: ext flag settable in any q phase
    // control register: hardware set wins over software clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_control_r <= MIC_IRQ_CONTROL_RST;
        end else begin
            if (wr_ctl) begin
                irq_control_r <= wbyte;
            end
            // RULE5: entry clears global
            if (accept) begin
                irq_control_r[MIC_GIE_BIT] <= 1'b0;
            end
            // RULE4: return sets global
            if (core_ev.return_from_isr) begin
                irq_control_r[MIC_GIE_BIT] <= 1'b1;
            end
            if (ext_edge) begin
                irq_control_r[MIC_EXTIF_BIT] <= 1'b1;
            end
            if (timer0_rollover) begin
                irq_control_r[MIC_TIMER0_OVERFLOW_FLAG_BIT] <= 1'b1;
            end
            if (port_change) begin
                irq_control_r[MIC_PCIF_BIT] <= 1'b1;
            end
        end
    end

    // RULE6: peripheral flags and enables
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            periph_flags_r <= MIC_PERIPH_RST;
            periph_enables_r <= MIC_PERIPH_RST;
            option_r <= MIC_OPTION_RST;
        end else begin
            if (wr_pen) begin
                periph_enables_r <= wbyte & MIC_PERIPH_MASK;
            end
            if (wr_opt) begin
                option_r <= wbyte;
            end
            periph_flags_r <= ((wr_pflag ? wbyte : periph_flags_r) | periph_set)
                              & MIC_PERIPH_MASK;
        end
    end

    // RULE9: nop after global clear
    // software clear of global enable masks the q1 request sample until the next q4
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gie_clr_nop_r <= 1'b0;
        end else if (wr_ctl && !wbyte[MIC_GIE_BIT]) begin
            gie_clr_nop_r <= 1'b1;
        end else if (q4) begin
            gie_clr_nop_r <= 1'b0;
        end
    end
    assign force_nop = gie_clr_nop_r;

    // RULE7: latency count
    // request sampled at q1, vector after three instruction cycles
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lat_cnt_r <= 2'd0;
        end else if (state_r == MIC_RUN && irq_request && !gie_clr_nop_r && q1) begin
            lat_cnt_r <= 2'(MIC_SYNC_LATENCY_TCY - 1);
        end else if (state_r == MIC_ENTRY && q4 && lat_cnt_r != 2'd0) begin
            lat_cnt_r <= lat_cnt_r - 2'd1;
        end
    end

    // RULE12: ext wake
    // RULE19: wake ignores global
    // sequencer: run, entry wait, sleep
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= MIC_RUN;
        end else begin
            case (state_r)
                MIC_RUN: begin
                    if (irq_request && !gie_clr_nop_r && q1) begin
                        state_r <= MIC_ENTRY;
                    end else if (core_ev.sleep_enter && !any_pending) begin
                        state_r <= MIC_SLEEP;
                    end
                end
                MIC_ENTRY: begin
                    if (accept) begin
                        state_r <= MIC_RUN;
                    end
                end
                MIC_SLEEP: begin
                    if (any_pending) begin
                        state_r <= MIC_RUN;
                    end
                end
                default: begin
                    state_r <= MIC_RUN;
                end
            endcase
        end
    end
    assign accept = state_r == MIC_ENTRY && q4 && lat_cnt_r == 2'd0;
    assign sleeping = state_r == MIC_SLEEP;
    assign wake_up = state_r == MIC_SLEEP && any_pending;

    // RULE5: push and vector
    // RULE17: only pc saved
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vector_load <= 1'b0;
            stack_push <= 1'b0;
            vector_pc <= '0;
            stack_push_pc <= '0;
        end else begin
            vector_load <= accept;
            stack_push <= accept;
            if (accept) begin
                vector_pc <= PC_W'(MIC_VECTOR);
                stack_push_pc <= next_pc;
            end
        end
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= MIC_AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= MIC_AXI_OKAY;
            case (s_axi_araddr)
                MIC_ADDR_IRQ_CONTROL: s_axi_rdata <= {24'h00_0000, irq_control_r};
                MIC_ADDR_PERIPH_FLAGS: s_axi_rdata <= {24'h00_0000, periph_flags_r};
                MIC_ADDR_PERIPH_ENABLES: s_axi_rdata <= {24'h00_0000, periph_enables_r};
                MIC_ADDR_OPTION: s_axi_rdata <= {24'h00_0000, option_r};
                MIC_ADDR_CPU_STATUS: begin
                    s_axi_rdata <= {24'h00_0000, 3'b000, state_r, q_phase_r};
                end
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= MIC_AXI_DECERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;
endmodule : mic_irq_ctrl

/* File: test/mic_irq_ctrl_checker.sv */
`timescale 1ns/1ps
module mic_irq_ctrl_checker
    import mic_pkg::*;
#(
    parameter int PC_W = 13
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] q_phase,
    input wire logic irq_request,
    input wire logic force_nop,
    input wire logic vector_load,
    input wire logic [PC_W-1:0] vector_pc,
    input wire logic stack_push,
    input wire logic sleeping,
    input wire logic wake_up
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [7:0] req_run_r;
    // cycles the cpu request has been held
    always_ff @(posedge aclk) begin
        if (!aresetn || !irq_request) begin
            req_run_r <= 8'h00;
        end else if (req_run_r != 8'hff) begin
            req_run_r <= req_run_r + 8'h01;
        end
    end
    vec_addr_a: assert property (vector_load |-> vector_pc == MIC_VECTOR[PC_W-1:0])
        else $error("vector address wrong");
    push_with_vec_a: assert property (vector_load |-> stack_push)
        else $error("no push on vector");
    vec_gie_clear_a: assert property (vector_load |-> !irq_request)
        else $error("request left on at entry");
    vec_pulse_a: assert property (vector_load |=> !vector_load)
        else $error("vector load too long");
    reset_no_req_a: assert property ($rose(aresetn) |-> !irq_request)
        else $error("request right after reset");
    entry_latency_a: assert property (vector_load |-> req_run_r inside {[8:16]})
        else $error("entry latency out of range");
    wake_in_sleep_a: assert property (wake_up |-> sleeping)
        else $error("wake while running");
    wake_leaves_a: assert property (wake_up |=> !sleeping)
        else $error("wake did not end sleep");
    phase_step_a: assert property (!sleeping ##1 !sleeping |-> q_phase == $past(q_phase) + 2'd1)
        else $error("phase did not advance");
    sleep_hold_a: assert property (sleeping ##1 sleeping |-> $stable(q_phase))
        else $error("phase ran in sleep");
    // main scenarios reached
    cover property (vector_load);
    cover property (wake_up);
    cover property (force_nop);
endmodule : mic_irq_ctrl_checker

bind mic_irq_ctrl mic_irq_ctrl_checker #(.PC_W(PC_W)) u_chk (.*);

/* File: test/mic_core_model.sv */
`timescale 1ns/1ps
module mic_core_model
    import mic_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] q_phase,
    input wire logic vector_load,
    input wire logic do_return_from_isr,
    input wire logic do_sleep,
    output mic_core_ev_type core_ev,
    output logic [12:0] next_pc,
    output logic [7:0] vec_count
);
    // return address offered
    // program counter steps per instruction, jumps on entry
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            next_pc <= 13'h0000;
        end else if (vector_load) begin
            next_pc <= MIC_VECTOR;
        end else if (q_phase == MIC_Q4) begin
            next_pc <= next_pc + 13'h0001;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vec_count <= 8'h00;
        end else if (vector_load) begin
            vec_count <= vec_count + 8'h01;
        end
    end
    assign core_ev = {q_phase == MIC_Q4, do_return_from_isr, do_sleep};
endmodule : mic_core_model

/* File: test/mcu_interrupt_controller_tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("[ERR] %0t %h %h", $time, (a), (b)); end end
module mcu_interrupt_controller_tb_top
    import mic_pkg::*;
;
    localparam logic [9:0] A_CTL = MIC_ADDR_IRQ_CONTROL;
    localparam logic [9:0] A_PFL = MIC_ADDR_PERIPH_FLAGS;
    localparam logic [9:0] A_PEN = MIC_ADDR_PERIPH_ENABLES;
    localparam logic [9:0] A_OPT = MIC_ADDR_OPTION;
    logic aclk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic irq_request, force_nop, vector_load, stack_push, sleeping, wake_up;
    logic aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ext_irq_pin = 1'b0, port_read = 1'b0;
    logic timer0_rollover = 1'b0, do_return_from_isr = 1'b0, do_sleep = 1'b0;
    logic [MIC_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, lfsr_r, rd;
    logic [3:0] s_axi_wstrb = 4'h1, port_upper_pins = 4'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp, q_phase, rsp;
    logic [12:0] next_pc, vector_pc, stack_push_pc;
    logic [7:0] vec_count;
    mic_periph_ev_type periph_ev = '0;
    mic_core_ev_type core_ev;
    int bad_count, total_checks;
    int nop_cnt = 0;
    int nop_base;

    // counts cycles with the forced nop shown, so a one-clock pulse is not missed
    always @(posedge aclk) begin
        if (force_nop) begin
            nop_cnt++;
        end
    end

    mic_irq_ctrl dut (.*);
    mic_core_model u_core (.aclk(aclk), .aresetn(aresetn), .q_phase(q_phase),
        .vector_load(vector_load), .do_return_from_isr(do_return_from_isr), .do_sleep(do_sleep),
        .core_ev(core_ev), .next_pc(next_pc), .vec_count(vec_count));

    // 50 MHz clock
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // peripheral strobe index to flag bit, bit 3 skipped
    function automatic logic [7:0] flag_of(input int i);
        return 8'h01 << ((i < 3) ? i : i + 1);
    endfunction : flag_of

    task automatic axi_wr(input logic [9:0] a, input logic [7:0] d);
        int n;
        logic aw_t, w_t, b_t;
        logic [1:0] br;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // handshakes judged on settled values, acted on after the edge
        do begin
            @(negedge aclk);
            aw_t = s_axi_awvalid && s_axi_awready;
            w_t = s_axi_wvalid && s_axi_wready;
            b_t = s_axi_bvalid;
            br = s_axi_bresp;
            @(posedge aclk);
            n++;
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
        end while (!b_t && n < 50);
        s_axi_bready <= 1'b0;
        `CHK(b_t, 1'b1)
        `CHK(br, MIC_AXI_OKAY)
    endtask : axi_wr

    task automatic axi_rd(input logic [9:0] a);
        int n;
        logic ar_t, r_t;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            ar_t = s_axi_arvalid && s_axi_arready;
            r_t = s_axi_rvalid;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge aclk);
            n++;
            if (ar_t) s_axi_arvalid <= 1'b0;
        end while (!r_t && n < 50);
        s_axi_rready <= 1'b0;
        `CHK(r_t, 1'b1)
    endtask : axi_rd

    task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
        axi_rd(a);
        `CHK(rd, {24'h00_0000, e})
        `CHK(rsp, MIC_AXI_OKAY)
    endtask : rd_chk

    task automatic pulse_ev(input logic [6:0] p, input logic t0);
        periph_ev <= mic_periph_ev_type'(p);
        timer0_rollover <= t0;
        @(posedge aclk);
        periph_ev <= '0;
        timer0_rollover <= 1'b0;
        repeat (6) @(posedge aclk);
    endtask : pulse_ev

    task automatic wait_vec;
        int n;
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (!vector_load && n < 40);
        `CHK(vector_load, 1'b1)
        `CHK(stack_push, 1'b1)
        `CHK(vector_pc, MIC_VECTOR)
        @(posedge aclk);
    endtask : wait_vec

    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    // hang guard
    initial begin
        repeat (6000) @(posedge aclk);
        bad_count++;
        final_report();
    end

    // main sequence
    initial begin
        lfsr_r = 32'h5153_cbb5;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_chk(A_CTL, MIC_IRQ_CONTROL_RST);
        rd_chk(A_PFL, MIC_PERIPH_RST);
        rd_chk(A_PEN, MIC_PERIPH_RST);
        rd_chk(A_OPT, MIC_OPTION_RST);
        axi_rd(10'h3fc);
        `CHK(rsp, MIC_AXI_DECERR)
        lfsr_r = lfsr_next(lfsr_r);
        axi_wr(A_PEN, lfsr_r[7:0]);
        rd_chk(A_PEN, lfsr_r[7:0] & MIC_PERIPH_MASK);
        // every peripheral source, global enable off
        for (int i = 0; i < 7; i++) begin
            pulse_ev(7'h01 << i, 1'b0);
            rd_chk(A_PFL, flag_of(i));
            axi_wr(A_PFL, 8'h00);
        end
        pulse_ev(7'h00, 1'b1);
        rd_chk(A_CTL, 8'h04);
        port_upper_pins <= lfsr_r[11:8] | 4'h1;
        repeat (6) @(posedge aclk);
        rd_chk(A_CTL, 8'h05);
        port_upper_pins <= 4'h0;
        repeat (6) @(posedge aclk);
        axi_wr(A_CTL, 8'h00);
        ext_irq_pin <= 1'b1;
        repeat (6) @(posedge aclk);
        rd_chk(A_CTL, 8'h02);
        axi_wr(A_CTL, 8'h00);
        axi_wr(A_OPT, 8'hbf);
        ext_irq_pin <= 1'b0;
        repeat (6) @(posedge aclk);
        rd_chk(A_CTL, 8'h02);
        axi_wr(A_CTL, 8'h00);
        ext_irq_pin <= 1'b1;
        repeat (6) @(posedge aclk);
        rd_chk(A_CTL, 8'h00);
        // peripheral request held back by its group enable
        axi_wr(A_PEN, 8'h01);
        pulse_ev(7'h01, 1'b0);
        axi_wr(A_CTL, 8'h80);
        `CHK(irq_request, 1'b0)
        axi_wr(A_CTL, 8'hc0);
        `CHK(irq_request, 1'b1)
        wait_vec();
        @(posedge aclk);
        rd_chk(A_CTL, 8'h40);
        axi_wr(A_PFL, 8'h00);
        do_return_from_isr <= 1'b1;
        @(posedge aclk);
        do_return_from_isr <= 1'b0;
        @(posedge aclk);
        rd_chk(A_CTL, 8'hc0);
        nop_base = nop_cnt;
        axi_wr(A_CTL, 8'h40);
        repeat (2) @(posedge aclk);
        `CHK(nop_cnt > nop_base, 1'b1)
        pulse_ev(7'h01, 1'b0);
        `CHK(irq_request, 1'b0)
        axi_wr(A_CTL, 8'hc0);
        wait_vec();
        axi_wr(A_PFL, 8'h00);
        axi_wr(A_CTL, 8'h10);
        do_sleep <= 1'b1;
        @(posedge aclk);
        do_sleep <= 1'b0;
        repeat (3) @(posedge aclk);
        `CHK(sleeping, 1'b1)
        ext_irq_pin <= 1'b0;
        repeat (20) begin
            @(negedge aclk);
            if (wake_up) break;
        end
        `CHK(wake_up, 1'b1)
        @(posedge aclk);
        repeat (20) @(posedge aclk);
        `CHK(sleeping, 1'b0)
        `CHK(vec_count, 8'h02)
        final_report();
    end
endmodule : mcu_interrupt_controller_tb_top
